// ==== bench/sbs_agent_model.sv ====
// sbs_agent_model: behavioural external agent facing the sequencer's bus.
// assumes the bench resolves the shared wires from the processor's enables alone.
`timescale 1ns/1ps
module sbs_agent_model #(
  parameter int LINE_WORDS = 8
) (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire logic [31:0]       busDataOut,
  input  wire logic [4:0]        cmdOut,
  input  wire logic              busDataOe,
  input  wire logic              proc_drive_valid_n,
  input  wire logic              proc_owns_bus_n,
  input  wire logic [3:0]        rspGap,
  input  wire logic              killArm,
  input  wire logic              xwrGo,
  input  wire sbs_pkg::sbs_xwr_t xwr,
  output logic [31:0]            agData,
  output logic [4:0]             agCmd,
  output logic                   agOe,
  output logic                   agent_drive_valid_n,
  output logic                   agent_accept_n,
  output logic                   agentBusRequest_n
);
  logic [31:0] rdAddr;
  logic        killDone = 1'b0;
  int          i;
  int          n;
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  // released wires float: show the inverse so a stale word never passes
  task automatic drop();
    agOe = 1'b0;
    agent_drive_valid_n = 1'b1;
    agData = ~agData;
    agCmd = ~agCmd;
  endtask
  task automatic put(input logic [4:0] c, input logic [31:0] d);
    agOe = 1'b1;
    agent_drive_valid_n = 1'b0;
    agCmd = c;
    agData = d;
    tick();
  endtask
  // wait for the release, then leave one undriven cycle
  task automatic waitSlave();
    while (!(proc_owns_bus_n === 1'b1 && busDataOe === 1'b0)) tick();
    tick();
  endtask
  initial begin
    agData = '0;
    agCmd = '0;
    agOe = 1'b0;
    agent_drive_valid_n = 1'b1;
    agent_accept_n = 1'b0;
    agentBusRequest_n = 1'b1;
  end
  always begin
    tick();
    agent_accept_n = 1'b0; // whole write data is taken at full rate
    if (killArm !== 1'b1) killDone = 1'b0;
    if (resetn === 1'b1 && xwrGo === 1'b1) begin
      agentBusRequest_n = 1'b0;
      waitSlave();
      agentBusRequest_n = 1'b1;
      put({1'b0, sbs_pkg::CMD_WR_SINGLE}, xwr.addr);
      put({1'b1, sbs_pkg::DID_LAST}, xwr.data);
    end else if (resetn === 1'b1 && proc_drive_valid_n === 1'b0 && cmdOut[4] === 1'b0
                 && cmdOut[3:1] === 3'b000) begin
      if (killArm === 1'b1 && !killDone) begin
        agent_accept_n = 1'b1; // kill once, then ignore the following cycle
        killDone = 1'b1;
        tick();
      end else begin
        rdAddr = busDataOut;
        n = (cmdOut[3:0] === sbs_pkg::CMD_RD_LINE) ? LINE_WORDS : 1;
        waitSlave();
        repeat (rspGap) tick(); // slow or prompt answer
        for (i = 0; i < n; i++) begin
          put({1'b1, (i == n - 1) ? sbs_pkg::DID_LAST : sbs_pkg::DID_MORE},
              rdAddr + 32'(i));
          if (i < n - 1 && rspGap != 0) begin
            drop();
            repeat (rspGap) tick();
          end
        end
      end
    end
    drop(); // hand the bus back once the request is done
  end
endmodule // sbs_agent_model

// ==== bench/sbs_seq_tb.sv ====
// sbs_seq_tb: self-checking bench for the system bus sequencer.
// assumes the agent model answers every processor read it accepts.
`timescale 1ns/1ps
module sbs_seq_tb;
  localparam int          LW = 8;
  localparam logic [31:0] AD = 32'h1000_0040;
  localparam logic [31:0] VX = 32'h0080_0000;
  logic               sys_clk = 1'b0;
  logic               resetn = 1'b0;
  logic               clkEn = 1'b1;
  logic               reqValid = 1'b0;
  logic               reqReady;
  sbs_pkg::sbs_req_t  req = '0;
  logic               wrDataValid = 1'b0;
  logic               wrDataReady;
  logic [31:0]        wrData = '0;
  logic               rspValid, doneValid, doneMerge, doneWriteBack, extWrValid;
  sbs_pkg::sbs_word_t rspWord;
  sbs_pkg::sbs_kind_t doneKind;
  sbs_pkg::sbs_xwr_t  extWr;
  sbs_pkg::sbs_xwr_t  xwr = '0;
  logic               bigEndianPin = 1'b0, user_reverse_byte_order = 1'b0;
  logic               userMode = 1'b0, byteOrderBig;
  logic [31:0]        busDataIn, busDataOut, agData;
  logic [4:0]         cmdIn, cmdOut, agCmd;
  logic               busDataOe, cmdOe, agOe, proc_drive_valid_n, agent_drive_valid_n;
  logic               agent_accept_n, agentBusRequest_n, proc_owns_bus_n;
  logic [3:0]         rspGap = '0;
  logic               killArm = 1'b0, xwrGo = 1'b0, fullSeen = 1'b0;
  logic [36:0]        pq[$];
  sbs_pkg::sbs_word_t rq[$];
  logic [4:0]         dq[$];
  sbs_pkg::sbs_xwr_t  xq[$];
  logic [31:0]        wq[$];
  int                 pt[$], dt[$];
  int                 cyc = 0, bad_count = 0, comparisons = 0, i;
  // the wire carries whoever enables; released lines show the model's float
  assign busDataIn = busDataOe ? busDataOut : agData;
  assign cmdIn = cmdOe ? cmdOut : agCmd;
  always #2.5 sys_clk = ~sys_clk;
  sbs_seq #(.LINE_WORDS(LW)) dut_u (.*);
  sbs_agent_model #(.LINE_WORDS(LW)) agent_u (.*);
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    chk(64'(busDataOe === 1'b1 && agOe === 1'b1), 0);
    if (proc_drive_valid_n === 1'b0) begin
      pq.push_back({cmdOut, busDataOut});
      pt.push_back(cyc);
    end
    if (rspValid === 1'b1) rq.push_back(rspWord);
    if (doneValid === 1'b1) begin
      dq.push_back({doneKind, doneMerge, doneWriteBack});
      dt.push_back(cyc);
    end
    if (extWrValid === 1'b1) xq.push_back(extWr);
    if (wrDataValid === 1'b1 && wrDataReady !== 1'b1) fullSeen = 1'b1;
    if (wrDataValid === 1'b1 && wrDataReady === 1'b1) void'(wq.pop_front());
    if (cyc == 4000) begin
      bad_count++;
      results();
    end
  end
  always @(posedge sys_clk) begin
    #1;
    wrDataValid = wq.size() > 0;
    if (wq.size() > 0) wrData = wq[0];
  end
  task automatic clr();
    pq.delete();
    pt.delete();
    rq.delete();
    dq.delete();
    dt.delete();
  endtask
  task automatic issue(input sbs_pkg::sbs_kind_t k, input logic [31:0] a, input logic d);
    tick();
    reqValid = 1'b1;
    req = '{k, a, d, a ^ VX};
    while (reqReady !== 1'b1) tick();
    tick();
    reqValid = 1'b0;
  endtask
  task automatic settle(input int nd);
    repeat (600) if (dq.size() < nd) tick();
    repeat (6) tick();
  endtask
  task automatic t_order();
    for (i = 0; i < 8; i++) begin
      {bigEndianPin, user_reverse_byte_order, userMode} = 3'(i);
      tick();
      tick();
      chk(byteOrderBig, i[2] ^ (i[1] & i[0]));
    end
    clkEn = 1'b0;
    {bigEndianPin, user_reverse_byte_order, userMode} = 3'b100;
    tick();
    tick();
    chk(byteOrderBig, 0); // held while the clock enable is low
    clkEn = 1'b1;
    {bigEndianPin, user_reverse_byte_order, userMode} = 3'b000;
  endtask
  task automatic t_uncLoad();
    clr();
    rspGap = 4'h5;
    {user_reverse_byte_order, userMode} = 2'b11;
    issue(sbs_pkg::KIND_UNC_LOAD, AD, 1'b0);
    repeat (3) tick();
    chk(reqReady, 0);
    settle(1);
    chk(pq.size(), 1);
    chk(pq[0], {1'b0, sbs_pkg::CMD_RD_SINGLE, AD});
    chk(rq.size(), 1);
    chk(rq[0], {32'h4000_0010, 1'b1});
    chk(dq[0], {sbs_pkg::KIND_UNC_LOAD, 2'b00});
    {user_reverse_byte_order, userMode} = 2'b00;
  endtask
  task automatic t_line();
    clr();
    rspGap = 4'h0;
    issue(sbs_pkg::KIND_IFETCH_MISS, AD, 1'b0);
    settle(1);
    chk(pq.size(), 1);
    chk(pq[0], {1'b0, sbs_pkg::CMD_RD_LINE, AD});
    for (i = 0; i < LW; i++) chk(rq[i], {AD + 32'(i), i == LW - 1});
    chk(dq[0], {sbs_pkg::KIND_IFETCH_MISS, 2'b00});
  endtask
  task automatic t_dirty();
    clr();
    for (i = 0; i < LW; i++) wq.push_back(32'hC0DE_0000 + 32'(i));
    rspGap = 4'h2;
    issue(sbs_pkg::KIND_LOAD_MISS, AD + 32'h0000_0100, 1'b1);
    settle(2);
    chk(pq.size(), LW + 2);
    chk(pq[1], {1'b0, sbs_pkg::CMD_WR_LINE, (AD + 32'h0000_0100) ^ VX});
    chk(64'(pt[1] > dt[0]), 1);
    for (i = 0; i < LW; i++)
      chk(pq[i + 2], {1'b1, (i == LW - 1) ? sbs_pkg::DID_LAST : sbs_pkg::DID_MORE,
                      32'hC0DE_0000 + 32'(i)});
    chk(dq[1], {sbs_pkg::KIND_LOAD_MISS, 2'b01});
    chk(fullSeen, 1); // buffer refused while the write-back waited
  endtask
  task automatic t_stores();
    clr();
    wq.push_back(32'h0000_AAAA);
    wq.push_back(32'h0000_BBBB);
    issue(sbs_pkg::KIND_UNC_STORE, AD, 1'b0);
    issue(sbs_pkg::KIND_UNC_STORE, AD + 32'h0000_0002, 1'b0);
    settle(2);
    chk(pq.size(), 4);
    for (i = 0; i < 2; i++) begin
      chk(pq[2 * i], {1'b0, sbs_pkg::CMD_WR_SINGLE, AD + 32'(2 * i)});
      chk(pq[2 * i + 1], {1'b1, sbs_pkg::DID_LAST,
                          (i == 0) ? 32'h0000_AAAA : 32'h0000_BBBB});
    end
    chk(dq.size(), 2);
  endtask
  task automatic t_ext();
    xwr = '{32'h0000_0200, 32'h5A5A_0001};
    xwrGo = 1'b1;
    tick();
    tick();
    xwrGo = 1'b0;
    repeat (100) if (xq.size() == 0) tick();
    repeat (6) tick();
    chk(xq.size(), 1);
    chk(xq[0], xwr);
    chk(proc_owns_bus_n, 0);
  endtask
  task automatic t_storeMiss();
    clr();
    killArm = 1'b1;
    rspGap = 4'h1;
    issue(sbs_pkg::KIND_STORE_MISS, AD + 32'h0000_0200, 1'b0);
    settle(1);
    killArm = 1'b0;
    chk(pq.size(), 3);
    for (i = 1; i < 3; i++)
      chk(pq[i], {1'b0, sbs_pkg::CMD_RD_LINE, AD + 32'h0000_0200});
    chk(dq[0], {sbs_pkg::KIND_STORE_MISS, 2'b10});
  endtask
  initial begin
    repeat (4) tick();
    resetn = 1'b1;
    t_order();
    t_uncLoad();
    t_line();
    t_dirty();
    t_stores();
    t_ext();
    t_storeMiss();
    results();
  end
endmodule // sbs_seq_tb

// ==== rtl/sbs_pair_buf.sv ====
// sbs_pair_buf: small flip-flop buffer with valid/ready on both sides.
// assumes the drain side may stall indefinitely; the fill side sees that as inReady low.
`timescale 1ns/1ps
module sbs_pair_buf #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  input  wire logic             clkEn,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic [WIDTH-1:0]      outData
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_chk
    $error("sbs_pair_buf: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wrPtr_reg;
  logic [AW-1:0]    rdPtr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign inReady  = clkEn && count_reg != (AW+1)'(DEPTH);
  assign outValid = count_reg != '0;
  assign outData  = mem_reg[rdPtr_reg];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge sys_clk) begin
    if (clkEn && push) begin
      mem_reg[wrPtr_reg] <= inData;
    end
  end

  // power-of-two depth lets the pointers wrap without a compare
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else if (clkEn) begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // sbs_pair_buf

// ==== rtl/sbs_pkg.sv ====
// sbs_pkg: constants, state codes and carriers shared by the system bus sequencer.
// assumes a single clock domain; all bus pins are synchronous to sys_clk.
package sbs_pkg;
  localparam int ADW            = 32;
  localparam int CMDW           = 5;
  localparam int CMD_DATA_BIT   = 4;
  localparam int LINE_WORDS_DEF = 8;
  localparam int BUF_DEPTH_DEF  = 2;

  // command and data identifier codes for the low four command bits
  localparam logic [3:0] CMD_RD_LINE   = 4'h0;
  localparam logic [3:0] CMD_RD_SINGLE = 4'h1;
  localparam logic [3:0] CMD_WR_LINE   = 4'h2;
  localparam logic [3:0] CMD_WR_SINGLE = 4'h3;
  localparam logic [3:0] DID_MORE      = 4'h0;
  localparam logic [3:0] DID_LAST      = 4'h1;

  localparam logic RST_OWNS_N  = 1'b0;
  localparam logic RST_VALID_N = 1'b1;
  localparam logic RST_OE      = 1'b1;

  typedef enum logic [2:0] {
    KIND_IFETCH_MISS = 3'b000,
    KIND_LOAD_MISS   = 3'b001,
    KIND_STORE_MISS  = 3'b010,
    KIND_UNC_LOAD    = 3'b011,
    KIND_UNC_STORE   = 3'b100
  } sbs_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ADDR   = 3'b001,
    ST_WDATA  = 3'b010,
    ST_REL    = 3'b011,
    ST_SLAVE  = 3'b100,
    ST_RETAKE = 3'b101
  } sbs_state_t;

  typedef struct packed {
    sbs_kind_t        kind;
    logic [ADW-1:0]   addr;
    logic             victimDirty;
    logic [ADW-1:0]   victimAddr;
  } sbs_req_t;

  typedef struct packed {
    logic [ADW-1:0] data;
    logic           last;
  } sbs_word_t;

  typedef struct packed {
    logic [ADW-1:0] addr;
    logic [ADW-1:0] data;
  } sbs_xwr_t;

  function automatic logic [ADW-1:0] swapBytes(input logic [ADW-1:0] w, input logic en);
    return en ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction
endpackage

// ==== rtl/sbs_seq.sv ====
// sbs_seq: processor-side request sequencer for the multiplexed system bus.
// assumes bus pins are sampled and driven synchronously; the pad ring resolves the enables.
`timescale 1ns/1ps
// Overview of operation
// - no new request of any kind while a read awaits response data.
// - a read completes when its last response word arrives.
// - a write completes when its last data word has been sent.
// - processor owns bus by default; agent returns it when done.
// - cache misses issue a whole-line read, then wait for response.
// - dirty victim line is written back only after the refill read.
// - store miss reads the line first, then the store is merged.
// - uncached load reads exactly one response word.
// - uncached store writes exactly one data word.
// - uncached writes are never combined into larger writes.
// - bus byte order is big-endian when the byte-order pin is high.
// - reverse-byte-order bit inverts byte order in user mode.
// - address cycles carry the physical address on all 32 lines.
// - command and address/data buses are two-way, driven by requester.
// - a request is address, command, then data for writes and responses.
// - top command bit: 0 means command, 1 means data identifier.
// - drive-valid strobe is low in each cycle the processor drives valid values.
// - back-to-back transactions and response data every cycle are taken.
// - agent requests bus; processor releases it, retakes after the request.
// - processor releases bus itself after a read request.
module sbs_seq #(
  parameter int LINE_WORDS = sbs_pkg::LINE_WORDS_DEF,
  parameter int BUF_DEPTH  = sbs_pkg::BUF_DEPTH_DEF
) (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic                       clkEn,
  input  wire logic                       reqValid,
  output logic                            reqReady,
  input  wire sbs_pkg::sbs_req_t          req,
  input  wire logic                       wrDataValid,
  output logic                            wrDataReady,
  input  wire logic [sbs_pkg::ADW-1:0]    wrData,
  output logic                            rspValid,
  output sbs_pkg::sbs_word_t              rspWord,
  output logic                            doneValid,
  output sbs_pkg::sbs_kind_t              doneKind,
  output logic                            doneMerge,
  output logic                            doneWriteBack,
  output logic                            extWrValid,
  output sbs_pkg::sbs_xwr_t               extWr,
  input  wire logic                       bigEndianPin,
  input  wire logic                       user_reverse_byte_order,
  input  wire logic                       userMode,
  output logic                            byteOrderBig,
  input  wire logic [sbs_pkg::ADW-1:0]    busDataIn,
  output logic [sbs_pkg::ADW-1:0]         busDataOut,
  output logic                            busDataOe,
  input  wire logic [sbs_pkg::CMDW-1:0]   cmdIn,
  output logic [sbs_pkg::CMDW-1:0]        cmdOut,
  output logic                            cmdOe,
  output logic                            proc_drive_valid_n,
  input  wire logic                       agent_drive_valid_n,
  input  wire logic                       agent_accept_n,
  input  wire logic                       agentBusRequest_n,
  output logic                            proc_owns_bus_n
);
  localparam int CW = $clog2(LINE_WORDS + 1);
  localparam logic [CW-1:0] LINE_CNT = CW'(LINE_WORDS);
  localparam logic [CW-1:0] ONE_CNT  = CW'(1);

  if (LINE_WORDS < 2 || LINE_WORDS > 64) begin : g_chk
    $error("sbs_seq: LINE_WORDS must lie between 2 and 64");
  end

  function automatic logic isRead(input logic [3:0] c);
    return c == sbs_pkg::CMD_RD_LINE || c == sbs_pkg::CMD_RD_SINGLE;
  endfunction

  function automatic logic [3:0] cmdOf(input sbs_pkg::sbs_kind_t k);
    unique case (k)
      sbs_pkg::KIND_UNC_LOAD:  return sbs_pkg::CMD_RD_SINGLE;
      sbs_pkg::KIND_UNC_STORE: return sbs_pkg::CMD_WR_SINGLE;
      default:                 return sbs_pkg::CMD_RD_LINE;
    endcase
  endfunction

  sbs_pkg::sbs_state_t      state_reg;
  sbs_pkg::sbs_kind_t       kind_reg;
  logic [3:0]               cmd_reg;
  logic [CW-1:0]            cnt_reg;
  logic [CW-1:0]            readLen_reg;
  logic                     readPending_reg;
  logic                     wbPending_reg;
  logic [sbs_pkg::ADW-1:0]  wbAddr_reg;
  logic                     xExpect_reg;
  logic [sbs_pkg::ADW-1:0]  xAddr_reg;
  logic [sbs_pkg::ADW-1:0]  busOut_reg;
  logic [sbs_pkg::CMDW-1:0] cmdOut_reg;
  logic                     validN_reg;
  logic                     oe_reg;
  logic                     ownsN_reg;
  logic                     bufValid;
  logic [sbs_pkg::ADW-1:0]  bufData;
  logic                     idle;
  logic                     launchWb;
  logic                     take;
  logic                     release_bus;
  logic                     accepted;
  logic                     sendWord;
  logic                     writeDone;
  logic                     rxValid;
  logic                     rxAddr;
  logic                     rxData;
  logic                     xDone;
  logic                     rxRsp;
  logic                     rxLast;
  logic                     swapNow;

  // store data waits here so a slow agent never drops a word
  sbs_pair_buf #(
    .WIDTH (sbs_pkg::ADW),
    .DEPTH (BUF_DEPTH)
  ) u_wbuf (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .clkEn    (clkEn),
    .inValid  (wrDataValid),
    .inReady  (wrDataReady),
    .inData   (wrData),
    .outValid (bufValid),
    .outReady (sendWord),
    .outData  (bufData)
  );

  assign swapNow     = user_reverse_byte_order && userMode;
  assign idle        = clkEn && state_reg == sbs_pkg::ST_IDLE; // no handshake while frozen
  assign launchWb    = idle && wbPending_reg && !readPending_reg;
  assign reqReady    = idle && !wbPending_reg && !readPending_reg && agentBusRequest_n;
  assign take        = reqValid && reqReady;
  assign release_bus = idle && !launchWb && !agentBusRequest_n;
  assign accepted    = state_reg == sbs_pkg::ST_ADDR && !agent_accept_n;
  assign sendWord    = state_reg == sbs_pkg::ST_WDATA && cnt_reg != '0 && bufValid;
  assign writeDone   = state_reg == sbs_pkg::ST_WDATA && cnt_reg == '0;
  assign rxValid     = state_reg == sbs_pkg::ST_SLAVE && !agent_drive_valid_n;
  assign rxAddr      = rxValid && !cmdIn[sbs_pkg::CMD_DATA_BIT];
  assign rxData      = rxValid && cmdIn[sbs_pkg::CMD_DATA_BIT];
  assign xDone       = rxData && xExpect_reg;
  assign rxRsp       = rxData && !xExpect_reg && readPending_reg;
  assign rxLast      = rxRsp && (cnt_reg + ONE_CNT == readLen_reg);

  assign busDataOut         = busOut_reg;
  assign cmdOut             = cmdOut_reg;
  assign busDataOe          = oe_reg;
  assign cmdOe              = oe_reg;
  assign proc_drive_valid_n = validN_reg;
  assign proc_owns_bus_n    = ownsN_reg;

  // bus ownership and pin drive
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg  <= sbs_pkg::ST_IDLE;
      busOut_reg <= '0;
      cmdOut_reg <= '0;
      validN_reg <= sbs_pkg::RST_VALID_N;
      oe_reg     <= sbs_pkg::RST_OE;
      ownsN_reg  <= sbs_pkg::RST_OWNS_N;
    end else if (clkEn) begin
      unique case (state_reg)
        sbs_pkg::ST_IDLE: begin
          validN_reg <= 1'b1;
          if (launchWb) begin
            state_reg  <= sbs_pkg::ST_ADDR;
            busOut_reg <= wbAddr_reg;
            cmdOut_reg <= {1'b0, sbs_pkg::CMD_WR_LINE};
            validN_reg <= 1'b0;
          end else if (release_bus) begin
            state_reg <= sbs_pkg::ST_REL;
            oe_reg    <= 1'b0;
            ownsN_reg <= 1'b1;
          end else if (take) begin
            state_reg  <= sbs_pkg::ST_ADDR;
            busOut_reg <= req.addr;
            cmdOut_reg <= {1'b0, cmdOf(req.kind)};
            validN_reg <= 1'b0;
          end
        end
        sbs_pkg::ST_ADDR: begin
          // a refused address cycle is simply repeated until the agent takes it
          if (accepted) begin
            validN_reg <= 1'b1;
            if (isRead(cmd_reg)) begin
              state_reg <= sbs_pkg::ST_REL;
              oe_reg    <= 1'b0;
              ownsN_reg <= 1'b1;
            end else begin
              state_reg <= sbs_pkg::ST_WDATA;
            end
          end
        end
        sbs_pkg::ST_WDATA: begin
          if (writeDone) begin
            state_reg  <= sbs_pkg::ST_IDLE;
            validN_reg <= 1'b1;
          end else if (sendWord) begin
            busOut_reg <= sbs_pkg::swapBytes(bufData, swapNow);
            cmdOut_reg <= {1'b1, (cnt_reg == ONE_CNT) ? sbs_pkg::DID_LAST : sbs_pkg::DID_MORE};
            validN_reg <= 1'b0;
          end else begin
            validN_reg <= 1'b1;
          end
        end
        sbs_pkg::ST_REL: begin
          state_reg <= sbs_pkg::ST_SLAVE;
        end
        sbs_pkg::ST_SLAVE: begin
          if (xDone || rxLast) begin
            state_reg <= sbs_pkg::ST_RETAKE;
          end
        end
        sbs_pkg::ST_RETAKE: begin
          // the agent stopped driving last cycle; we only drive from the next one
          state_reg <= sbs_pkg::ST_IDLE;
          oe_reg    <= 1'b1;
          ownsN_reg <= 1'b0;
        end
        default: begin
          state_reg <= sbs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // request bookkeeping
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      kind_reg        <= sbs_pkg::KIND_IFETCH_MISS;
      cmd_reg         <= sbs_pkg::CMD_RD_LINE;
      cnt_reg         <= '0;
      readLen_reg     <= '0;
      readPending_reg <= 1'b0;
      wbPending_reg   <= 1'b0;
      wbAddr_reg      <= '0;
      xExpect_reg     <= 1'b0;
      xAddr_reg       <= '0;
    end else if (clkEn) begin
      if (take) begin
        kind_reg <= req.kind;
        cmd_reg  <= cmdOf(req.kind);
        if (req.victimDirty && cmdOf(req.kind) == sbs_pkg::CMD_RD_LINE) begin
          wbPending_reg <= 1'b1;
          wbAddr_reg    <= req.victimAddr;
        end
      end
      if (launchWb) begin
        cmd_reg       <= sbs_pkg::CMD_WR_LINE;
        wbPending_reg <= 1'b0;
      end
      if (accepted) begin
        if (isRead(cmd_reg)) begin
          readPending_reg <= 1'b1;
          cnt_reg         <= '0;
          readLen_reg     <= (cmd_reg == sbs_pkg::CMD_RD_LINE) ? LINE_CNT : ONE_CNT;
        end else begin
          cnt_reg <= (cmd_reg == sbs_pkg::CMD_WR_LINE) ? LINE_CNT : ONE_CNT;
        end
      end
      if (sendWord) begin
        cnt_reg <= cnt_reg - ONE_CNT;
      end
      if (rxAddr) begin
        xExpect_reg <= 1'b1;
        xAddr_reg   <= busDataIn;
      end
      if (xDone) begin
        xExpect_reg <= 1'b0;
      end
      if (rxRsp) begin
        cnt_reg <= cnt_reg + ONE_CNT;
      end
      if (rxLast) begin
        readPending_reg <= 1'b0;
      end
    end
  end

  // user-side results
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rspValid      <= 1'b0;
      rspWord       <= '0;
      doneValid     <= 1'b0;
      doneKind      <= sbs_pkg::KIND_IFETCH_MISS;
      doneMerge     <= 1'b0;
      doneWriteBack <= 1'b0;
      extWrValid    <= 1'b0;
      extWr         <= '0;
      byteOrderBig  <= 1'b0;
    end else if (clkEn) begin
      rspValid      <= rxRsp;
      rspWord       <= '{data: sbs_pkg::swapBytes(busDataIn, swapNow), last: rxLast};
      doneValid     <= rxLast || writeDone;
      doneKind      <= kind_reg;
      doneMerge     <= rxLast && kind_reg == sbs_pkg::KIND_STORE_MISS;
      doneWriteBack <= writeDone && cmd_reg == sbs_pkg::CMD_WR_LINE;
      extWrValid    <= xDone;
      extWr         <= '{addr: xAddr_reg, data: busDataIn};
      byteOrderBig  <= bigEndianPin ^ swapNow;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn || !clkEn);

  one_read_a: assert property (readPending_reg |-> !reqReady && !launchWb)
    else $error("request possible while a read is pending");
  read_done_a: assert property (rxLast |=> !readPending_reg && doneValid)
    else $error("read did not complete on its last response word");
  write_done_a: assert property (sendWord && cnt_reg == ONE_CNT |=> writeDone ##1 doneValid)
    else $error("write did not complete after its last word");
  self_release_a: assert property (accepted && isRead(cmd_reg)
      |=> proc_owns_bus_n && !busDataOe ##1 state_reg == sbs_pkg::ST_SLAVE)
    else $error("bus not released after a read request");
  retake_gap_a: assert property ($fell(proc_owns_bus_n) |-> $past(!busDataOe) && busDataOe)
    else $error("bus retaken without an idle cycle");
  release_gap_a: assert property ($rose(proc_owns_bus_n) |-> !busDataOe && !cmdOe)
    else $error("bus still driven while released");
  proc_drive_valid_n_own_a: assert property (!proc_drive_valid_n |-> busDataOe && !proc_owns_bus_n)
    else $error("drive-valid asserted without driving the bus");
  addr_cycle_a: assert property (state_reg == sbs_pkg::ST_ADDR
      |-> !proc_drive_valid_n && cmdOut[3:0] == cmd_reg && !cmdOut[sbs_pkg::CMD_DATA_BIT])
    else $error("address cycle not marked as a command");
  wb_order_a: assert property (launchWb |-> !readPending_reg ##1 cmdOut == {1'b0, sbs_pkg::CMD_WR_LINE})
    else $error("write-back issued before the refill completed");
  unc_store_a: assert property (accepted && cmd_reg == sbs_pkg::CMD_WR_SINGLE |=> cnt_reg == ONE_CNT)
    else $error("uncached store not a single word");
  data_id_a: assert property (sendWord |=> cmdOut[sbs_pkg::CMD_DATA_BIT] && !proc_drive_valid_n)
    else $error("data word not marked as a data cycle");

  line_read_c: cover property (rxLast && readLen_reg == LINE_CNT);
  ext_write_c: cover property (extWrValid);
  writeback_c: cover property (doneWriteBack);
  killed_cmd_c: cover property (state_reg == sbs_pkg::ST_ADDR && agent_accept_n);
endmodule // sbs_seq
